// *** rtl/switch_monitor_spi_port.sv ***
// Serial host port, switch status capture and wake/interrupt pin logic
`timescale 1ns/1ps

module switch_monitor_spi_port (
  input  wire logic        clock,
  input  wire logic        reset_n,                      // Power-on reset from battery supply
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_si,
  input  wire logic        logic_supply_present,
  input  wire logic        thermal_flag,
  input  wire logic        sleep_request,                // Same-domain pulse from the sleep controller
  input  wire logic [7:0]  dual_polarity_switch_inputs,  // Comparator: 1 = above threshold
  input  wire logic [13:0] ground_only_switch_inputs,    // Comparator: 1 = above threshold
  input  wire logic        int_line_in,
  input  wire logic        wake_line_in,
  output logic             spi_so_out,
  output logic             spi_so_oe,
  output logic             int_out,
  output logic             int_oe,
  output logic             wake_out,
  output logic             wake_oe,
  output logic             normal_mode,
  output logic             int_level_captured,
  output logic [23:0]      command_word,
  output logic             command_valid
);

  localparam int SYNC_W = 7 + switch_monitor_pkg::SP_COUNT + switch_monitor_pkg::SG_COUNT;

  // ==========================================================================
  // Pin synchronisation
  logic [SYNC_W-1:0] sync_bus;
  logic              cs_s, sclk_s, si_s, vdd_s, int_s, wake_s, thermal_s;
  logic [7:0]        sp_level;
  logic [13:0]       sg_level;

  pin_sync #(
    .WIDTH       (SYNC_W),
    .RESET_VALUE ({7'h4c, 22'h003fff})   // Idle pin levels, so no false edge or change follows reset
  ) u_pin_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({spi_cs_n, spi_sclk, spi_si, logic_supply_present, int_line_in, wake_line_in, thermal_flag,
                dual_polarity_switch_inputs, ground_only_switch_inputs}),
    .sync_out (sync_bus)
  );

  assign {cs_s, sclk_s, si_s, vdd_s, int_s, wake_s, thermal_s, sp_level, sg_level} = sync_bus;

  // ==========================================================================
  // Edge detection on synchronised levels
  logic cs_d, sclk_d, int_d, wake_d;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_d   <= 1'b1;
      sclk_d <= 1'b0;
      int_d  <= 1'b1;
      wake_d <= 1'b0;                                   // Wake pin is pulled low while in reset
    end else begin
      cs_d   <= cs_s;
      sclk_d <= sclk_s;
      int_d  <= int_s;
      wake_d <= wake_s;
    end
  end

  wire cs_fall    = cs_d & ~cs_s;
  wire cs_rise    = ~cs_d & cs_s;
  wire selected   = ~cs_d & ~cs_s;                      // Clock edges only count while selected
  wire sclk_rise  = selected & ~sclk_d & sclk_s;
  wire sclk_fall  = selected & sclk_d & ~sclk_s;
  wire int_fall   = int_d & ~int_s;
  wire wake_fall  = wake_d & ~wake_s;

  // ==========================================================================
  // Configuration and switch closure decode
  switch_monitor_pkg::mode_t mode, next_mode;
  logic [7:0]  polarity;
  logic [7:0]  sp_enable;
  logic [13:0] sg_enable;
  logic [21:0] closed_prev;
  logic [7:0]  sp_closed;

  // Battery polarity closes above threshold, ground polarity below
  genvar gi;
  generate
    for (gi = 0; gi < switch_monitor_pkg::SP_COUNT; gi++) begin : g_sp
      assign sp_closed[gi] = polarity[gi] ? sp_level[gi] : ~sp_level[gi];
    end
  endgenerate

  wire [13:0] sg_closed   = ~sg_level;                 // Ground-only: low level is closed
  wire [21:0] closed_now  = {sg_closed, sp_closed};
  wire [21:0] enable_all  = {sg_enable, sp_enable};
  wire        change_now  = |((closed_now ^ closed_prev) & enable_all);
  wire        is_normal   = (mode == switch_monitor_pkg::MODE_NORMAL);

  // Previous closure state; a polarity change may flag one spurious change, which is safe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      closed_prev <= 22'h000000;
    end else begin
      closed_prev <= closed_now;
    end
  end

  // ==========================================================================
  // Serial shift logic
  logic [23:0] in_shift;
  logic [23:0] out_shift;
  logic [4:0]  bit_count;
  logic        reset_flag;

  // Status word: thermal, reset flag, ground-only then programmable closures
  wire [23:0] status_word = {thermal_s, reset_flag, sg_closed, sp_closed};
  wire        word_full   = (bit_count == switch_monitor_pkg::FULL_WORD_COUNT);
  wire        cmd_accept  = cs_rise & word_full & is_normal & vdd_s;
  wire [7:0]  cmd_code    = in_shift[switch_monitor_pkg::CMD_LSB +: 8];

  // Input word shifts in MSB first on falling clock edges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_shift  <= 24'h000000;
      bit_count <= 5'h00;
    end else if (cs_fall) begin
      bit_count <= 5'h00;
    end else if (sclk_fall) begin
      in_shift  <= {in_shift[22:0], si_s};
      bit_count <= (bit_count == switch_monitor_pkg::COUNT_SATURATE) ? bit_count : bit_count + 5'h01;
    end
  end

  // Status captured at select, one bit presented per rising clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_shift  <= 24'h000000;
      spi_so_out <= 1'b0;
    end else if (cs_fall) begin
      out_shift  <= status_word;
      spi_so_out <= 1'b0;
    end else if (sclk_rise) begin
      spi_so_out <= out_shift[23];
      out_shift  <= {out_shift[22:0], 1'b0};
    end
  end

  // Output driver enabled only inside a selection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      spi_so_oe <= 1'b0;
    end else if (cs_fall) begin
      spi_so_oe <= 1'b1;
    end else if (cs_rise) begin
      spi_so_oe <= 1'b0;
    end
  end

  // Reset flag stands from power-on until the first deselect
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_flag <= 1'b1;
    end else if (cs_rise) begin
      reset_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Command application at deselect
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      command_word  <= 24'h000000;
      command_valid <= 1'b0;
    end else begin
      command_valid <= cmd_accept;
      if (cmd_accept) begin
        command_word <= in_shift;
      end
    end
  end

  // Settings and wake/interrupt commands steer closure polarity and change detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      polarity  <= switch_monitor_pkg::POLARITY_RESET;
      sp_enable <= switch_monitor_pkg::SP_ENABLE_RESET;
      sg_enable <= switch_monitor_pkg::SG_ENABLE_RESET;
    end else if (cmd_accept) begin
      if (cmd_code == switch_monitor_pkg::CMD_SETTINGS) begin
        polarity <= in_shift[7:0];
      end
      if (cmd_code == switch_monitor_pkg::CMD_WAKE_SP) begin
        sp_enable <= in_shift[7:0];
      end
      if (cmd_code == switch_monitor_pkg::CMD_WAKE_SG) begin
        sg_enable <= in_shift[13:0];
      end
    end
  end

  // ==========================================================================
  // Interrupt pin
  logic int_pending;
  logic change_during_cs;

  // Changes seen while selected keep the interrupt through deselect
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      change_during_cs <= 1'b0;
    end else if (cs_fall) begin
      change_during_cs <= 1'b0;
    end else if (selected & is_normal & change_now) begin
      change_during_cs <= 1'b1;
    end else if (cs_rise) begin
      change_during_cs <= 1'b0;
    end
  end

  // A new change in the deselect cycle wins over the clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int_pending <= 1'b0;
    end else if (is_normal & change_now) begin
      int_pending <= 1'b1;
    end else if (cs_rise) begin
      int_pending <= change_during_cs;
    end
  end

  // Interrupt level caught at selection for the controller's reference
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int_level_captured <= 1'b1;
    end else if (cs_fall) begin
      int_level_captured <= int_s;
    end
  end

  // ==========================================================================
  // Mode control and wake pin
  wire wake_by_cs   = cs_fall & vdd_s;
  wire wake_by_int  = int_fall & wake_s & vdd_s;
  wire wake_by_wake = wake_fall & (int_s | ~vdd_s);
  wire wake_by_sw   = change_now;
  wire wake_any     = wake_by_cs | wake_by_int | wake_by_wake | wake_by_sw;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      switch_monitor_pkg::MODE_NORMAL: begin
        if (sleep_request) begin
          next_mode = switch_monitor_pkg::MODE_SLEEP;
        end
      end
      switch_monitor_pkg::MODE_SLEEP: begin
        if (wake_any) begin
          next_mode = switch_monitor_pkg::MODE_NORMAL;
        end
      end
    endcase
  end

  // Wake pin drives low in normal mode so it can gate a supply enable
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode        <= switch_monitor_pkg::MODE_NORMAL;
      normal_mode <= 1'b1;
      wake_oe     <= 1'b1;
      int_oe      <= 1'b0;
      int_out     <= 1'b0;
      wake_out    <= 1'b0;
    end else begin
      mode        <= next_mode;
      normal_mode <= (next_mode == switch_monitor_pkg::MODE_NORMAL);
      wake_oe     <= (next_mode == switch_monitor_pkg::MODE_NORMAL);
      int_oe      <= int_pending;
      int_out     <= 1'b0;
      wake_out    <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Thermal flag as seen at select: the MSB the first rising clock must present
  logic msb_at_select;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      msb_at_select <= 1'b0;
    end else if (cs_fall) begin
      msb_at_select <= thermal_s;
    end
  end

  sequence s_full_deselect;
    cs_rise && word_full && is_normal && vdd_s;
  endsequence

  sequence s_first_rise;
    sclk_rise && (bit_count == 5'h00);
  endsequence

  a_so_enable_at_select: assert property (cs_fall |=> spi_so_oe)
    else $error("Serial output not enabled after select");
  a_so_off_deselect: assert property (cs_rise |=> !spi_so_oe ##1 !spi_so_oe || cs_fall)
    else $error("Serial output still driven after deselect");
  a_idle_tristate: assert property (cs_d && cs_s |=> !spi_so_oe)
    else $error("Serial output driven while deselected");
  a_int_release: assert property (cs_rise && !change_during_cs && !(is_normal && change_now) |=> !int_pending ##1 !int_oe)
    else $error("Interrupt not released at deselect");
  a_int_hold: assert property (cs_rise && change_during_cs |=> int_pending ##1 int_oe)
    else $error("Interrupt cleared despite change during selection");
  a_cmd_apply: assert property (s_full_deselect |=> command_valid && (command_word == $past(in_shift)))
    else $error("Full command word not applied at deselect");
  a_cmd_discard: assert property (cs_rise && !word_full |=> !command_valid)
    else $error("Partial command word applied");
  a_first_bit_msb: assert property (s_first_rise |=> spi_so_out == msb_at_select)
    else $error("First output bit is not the status MSB");
  a_reset_flag_clear: assert property (cs_rise |=> !reset_flag)
    else $error("Reset flag not cleared at deselect");
  a_wake_pin_mode: assert property (wake_oe == (mode == switch_monitor_pkg::MODE_NORMAL))
    else $error("Wake pin drive does not follow mode");
  a_cs_wakes_sleep: assert property (!is_normal && cs_fall && vdd_s |=> is_normal)
    else $error("Select did not wake from sleep");
  a_wake_line_wakes: assert property (!is_normal && wake_fall && int_s |=> is_normal ##1 wake_oe)
    else $error("Wake line fall did not wake from sleep");

endmodule : switch_monitor_spi_port

// *** rtl/switch_monitor_pkg.sv ***
// Shared constants for the switch monitor serial port and wake/interrupt logic
package switch_monitor_pkg;

  // ==========================================================================
  // Word layout
  localparam int          WORD_BITS        = 24;
  localparam int          COUNT_W          = 5;
  localparam int          SP_COUNT         = 8;
  localparam int          SG_COUNT         = 14;
  localparam int          STAT_THERMAL_BIT = 23;
  localparam int          STAT_RESET_BIT   = 22;
  localparam int          STAT_SG_LSB      = 8;
  localparam int          STAT_SP_LSB      = 0;
  localparam logic [4:0]  FULL_WORD_COUNT  = 5'h18;
  localparam logic [4:0]  COUNT_SATURATE   = 5'h1f;

  // ==========================================================================
  // Command codes, carried in the top byte of a command word
  localparam int          CMD_LSB          = 16;
  localparam logic [7:0]  CMD_SETTINGS     = 8'h01;
  localparam logic [7:0]  CMD_WAKE_SP      = 8'h02;
  localparam logic [7:0]  CMD_WAKE_SG      = 8'h03;

  // ==========================================================================
  // Reset values: battery-switch polarity, every input enabled for wake-up
  localparam logic [7:0]  POLARITY_RESET   = 8'hff;
  localparam logic [7:0]  SP_ENABLE_RESET  = 8'hff;
  localparam logic [13:0] SG_ENABLE_RESET  = 14'h3fff;

  // ==========================================================================
  // Operating mode
  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_SLEEP  = 1'b1
  } mode_t;

endpackage : switch_monitor_pkg

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps

module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ==========================================================================
  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

// *** dv/spi_master_model.sv ***
// Behavioural controller that drives the serial port of the switch monitor
`timescale 1ns/1ps

module spi_master_model (
  input  wire logic        clock,
  input  wire logic        start,
  input  wire logic        no_select,
  input  wire logic [5:0]  bit_count,
  input  wire logic [23:0] tx_word,
  input  wire logic        spi_so,
  output logic             spi_cs_n,
  output logic             spi_sclk,
  output logic             spi_si,
  output logic [23:0]      rx_word,
  output logic             busy
);
  // ==========================================================================
  // Transfer engine
  // Pins move 7 ns after a clock edge, so the link never races the sampler
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si   = 1'b0;
    rx_word  = '0;
    busy     = 1'b0;
    forever begin
      @(posedge clock iff start);
      busy = 1'b1;
      #7;
      if (!no_select) spi_cs_n = 1'b0;                 // Clock is low at select
      #100;
      for (int i = 0; i < int'(bit_count); i++) begin
        spi_si   = tx_word[23 - (i % 24)];             // MSB first, whole words
        spi_sclk = 1'b1;
        #100 rx_word = {rx_word[22:0], spi_so};        // Sampled at the falling edge
        spi_sclk = 1'b0;
        #100;
      end
      spi_cs_n = 1'b1;                                 // Deselect with clock low
      spi_si   = ~spi_si;                              // Released line keeps no stale value
      #100 busy = 1'b0;
    end
  end

endmodule : spi_master_model

// *** dv/testbench.sv ***
// Self-checking bench for the switch monitor serial port
`timescale 1ns/1ps
`define check_eq(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; $display("ERROR %s expected %h seen %h", name, exp, got); end end

module testbench;
  // ==========================================================================
  // Stimulus and observation signals
  logic        clock = 1'b0, reset_n = 1'b0, supply = 1'b1, thermal = 1'b0, sleep_req = 1'b0;
  logic        int_pull = 1'b0, wake_pull = 1'b0, filler = 1'b0, start = 1'b0, no_sel = 1'b0;
  logic [7:0]  sp = '0;
  logic [13:0] sg = '0;
  logic [23:0] tx = '0, cmd_word, rx;
  logic [5:0]  bits = 6'h18;
  logic        so_out, so_oe, int_oe, wake_oe, normal, int_cap, cmd_valid, cs_n, sclk, si, busy;
  logic        so_wire, int_wire, wake_wire, int_low, wake_low;
  int          bad_count = 0, n_compared = 0, cycles = 0, cmd_count = 0, oe_cycles = 0, k, saved, oe_seen;

  typedef struct packed {
    logic [7:0]  sp;
    logic [13:0] sg;
    logic        th;
    logic [23:0] cmd;
    logic [23:0] status;
  } row_t;

  // Inputs beside the status word they should return; row four sees the polarity set by row three
  row_t rows [4] = '{
    '{8'ha5, 14'h0f0f, 1'b0, {switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, {2'b01, 14'h30f0, 8'ha5}},
    '{8'h5a, 14'h3000, 1'b1, {switch_monitor_pkg::CMD_WAKE_SG, 16'h3fff}, {2'b10, 14'h0fff, 8'h5a}},
    '{8'hff, 14'h3fff, 1'b0, {switch_monitor_pkg::CMD_SETTINGS, 16'h00f0}, {2'b00, 14'h0000, 8'hff}},
    '{8'hff, 14'h0000, 1'b0, {switch_monitor_pkg::CMD_SETTINGS, 16'h00ff}, {2'b00, 14'h3fff, 8'hf0}}};

  // ==========================================================================
  // Pin resolution: interrupt and wake wires have pull-ups, the data line has none
  assign so_wire   = so_oe ? so_out : filler;
  assign int_wire  = ~(int_oe | int_pull);
  assign wake_wire = ~(wake_oe | wake_pull);

  // ==========================================================================
  // Instances
  switch_monitor_spi_port u_dut (
    .clock(clock), .reset_n(reset_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si),
    .logic_supply_present(supply), .thermal_flag(thermal), .sleep_request(sleep_req),
    .dual_polarity_switch_inputs(sp), .ground_only_switch_inputs(sg), .int_line_in(int_wire),
    .wake_line_in(wake_wire), .spi_so_out(so_out), .spi_so_oe(so_oe), .int_out(int_low), .int_oe(int_oe),
    .wake_out(wake_low), .wake_oe(wake_oe), .normal_mode(normal), .int_level_captured(int_cap),
    .command_word(cmd_word), .command_valid(cmd_valid));

  spi_master_model u_master (
    .clock(clock), .start(start), .no_select(no_sel), .bit_count(bits), .tx_word(tx),
    .spi_so(so_wire), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si), .rx_word(rx), .busy(busy));

  // ==========================================================================
  // Clock, monitors and hang guard
  initial begin
    forever #12.5 clock = ~clock;
  end

  // A pulse counter is cheaper than a scoreboard; the guard is far above the expected run
  always @(posedge clock) begin
    filler <= ~filler;
    cycles <= cycles + 1;
    if (cmd_valid) cmd_count <= cmd_count + 1;
    if (so_oe) oe_cycles <= oe_cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic launch(input logic [23:0] w, input int n, input logic skip);
    tx     <= w;
    bits   <= 6'(n);
    no_sel <= skip;
    start  <= 1'b1;
    tick(1);
    start  <= 1'b0;
    tick(2);
  endtask : launch

  // Bounded wait on the controller, then room for the deselect to land
  task automatic finish_xfer;
    for (k = 0; k < 400 && busy; k++) tick(1);
    tick(8);
  endtask : finish_xfer

  task automatic xfer(input logic [23:0] w, input int n, input logic skip);
    launch(w, n, skip);
    finish_xfer();
  endtask : xfer

  task automatic sleep_now;
    sleep_req <= 1'b1;
    tick(1);
    sleep_req <= 1'b0;
    tick(3);
  endtask : sleep_now

  task automatic report_and_stop;
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Main sequence
  initial begin
    tick(3);
    reset_n <= 1'b1;
    tick(4);
    `check_eq("wake pin after reset", 1'b1, wake_oe)
    `check_eq("data idle", 1'b0, so_oe)
    foreach (rows[i]) begin
      sp      <= rows[i].sp;
      sg      <= rows[i].sg;
      thermal <= rows[i].th;
      tick(8);
      xfer(rows[i].cmd, 24, 1'b0);
      `check_eq("status", rows[i].status, rx)
      `check_eq("command", rows[i].cmd, cmd_word)
      `check_eq("command count", i + 1, cmd_count)
      `check_eq("data released", 1'b0, so_oe)
    end
    // Interrupt raise, capture, clear, and hold when a change lands mid-transfer
    xfer(24'h000000, 24, 1'b0);
    `check_eq("int idle", 1'b0, int_oe)
    sg <= sg ^ 14'h0001;
    tick(8);
    `check_eq("int raised", 1'b1, int_oe)
    `check_eq("int drive level", 1'b0, int_low)
    xfer(24'h000000, 24, 1'b0);
    `check_eq("int captured", 1'b0, int_cap)
    `check_eq("int cleared", 1'b0, int_oe)
    launch(24'h000000, 24, 1'b0);
    tick(60);
    sp <= 8'hfe;
    finish_xfer();
    `check_eq("latched at select", 8'hff, rx[7:0])
    `check_eq("int held", 1'b1, int_oe)
    // A disabled input raises no interrupt
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h0000}, 24, 1'b0);
    sp <= 8'hff;
    tick(8);
    `check_eq("int masked", 1'b0, int_oe)
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, 24, 1'b0);
    // Short and long words are thrown away, and clocks without select do nothing
    saved = cmd_count;
    xfer({switch_monitor_pkg::CMD_SETTINGS, 16'h0000}, 23, 1'b0);
    xfer({switch_monitor_pkg::CMD_SETTINGS, 16'h0000}, 25, 1'b0);
    `check_eq("short long refused", saved, cmd_count)
    `check_eq("word kept", {switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, cmd_word)
    oe_seen = oe_cycles;
    xfer(24'hffffff, 24, 1'b1);
    `check_eq("unselected clocks", saved, cmd_count)
    `check_eq("unselected data", oe_seen, oe_cycles)
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, 24, 1'b0);
    `check_eq("polarity kept", 8'hff, rx[7:0])
    // Sleep and the wake sources
    sleep_now();
    `check_eq("sleep wake pin", 1'b0, wake_oe)
    supply <= 1'b0;
    saved = cmd_count;
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, 24, 1'b0);
    `check_eq("unsupplied select", 1'b0, normal)
    `check_eq("unsupplied command", saved, cmd_count)
    int_pull <= 1'b1;
    tick(8);
    wake_pull <= 1'b1;
    tick(8);
    `check_eq("wake fall unsupplied", 1'b1, normal)
    `check_eq("wake pin driven", 1'b1, wake_oe)
    wake_pull <= 1'b0;
    supply    <= 1'b1;
    tick(8);
    sleep_now();
    wake_pull <= 1'b1;
    tick(8);
    `check_eq("wake fall int low", 1'b0, normal)
    wake_pull <= 1'b0;
    int_pull  <= 1'b0;
    tick(8);
    int_pull <= 1'b1;
    tick(8);
    `check_eq("int line wake", 1'b1, normal)
    int_pull <= 1'b0;
    tick(4);
    sleep_now();
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, 24, 1'b0);
    `check_eq("select wake", 1'b1, normal)
    // Reset in mid-run restores defaults and raises the reset flag again
    xfer({switch_monitor_pkg::CMD_SETTINGS, 16'h0000}, 24, 1'b0);
    reset_n <= 1'b0;
    tick(3);
    reset_n <= 1'b1;
    tick(4);
    `check_eq("normal after reset", 1'b1, normal)
    `check_eq("wake drive level", 1'b0, wake_low)
    `check_eq("command after reset", 24'h000000, cmd_word)
    `check_eq("data after reset", 1'b0, so_oe)
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, 24, 1'b0);
    `check_eq("reset flag set", {2'b01, 14'h3ffe, 8'hff}, rx)
    xfer({switch_monitor_pkg::CMD_WAKE_SP, 16'h00ff}, 24, 1'b0);
    `check_eq("reset flag cleared", {2'b00, 14'h3ffe, 8'hff}, rx)
    report_and_stop();
  end

endmodule : testbench
